// ---- rtl/beam_ext_pkg.sv ----
// Constants for the compact multi-port beamforming extension parser.
// Assumes one byte-stream clock shared by the whole control-plane receive path.
package beam_ext_pkg;
  // ****************************************************************
  // Header layout
  // ****************************************************************
  localparam logic [6:0] EXT_KIND_CODE     = 7'h13;
  localparam logic [3:0] SECTION_KIND_ONE  = 4'h1;
  localparam logic [3:0] SECTION_KIND_THREE = 4'h3;
  localparam int         MORE_FLAG_BIT     = 7;
  localparam int         WEIGHTS_OFF_BIT   = 7;
  localparam int         REPEAT_BIT        = 6;
  localparam int         PORT_COUNT_W      = 6;
  localparam int         MAX_PORTS         = 64;
  localparam int         SYMBOL_BITS       = 14;
  localparam int         ELEMENT_BITS      = 12;
  localparam int         BEAM_BITS         = 15;
  localparam int         LEN_UNIT_OCTETS   = 4;
  localparam logic [7:0] PAD_OCTET         = 8'h00;

  // ****************************************************************
  // Parser states
  // ****************************************************************
  typedef enum logic [3:0]
  {
    ST_IDLE    = 4'b0000,
    ST_LEN_HI  = 4'b0001,
    ST_LEN_LO  = 4'b0010,
    ST_FLAGS   = 4'b0011,
    ST_SYM_HI  = 4'b0100,
    ST_SYM_LO  = 4'b0101,
    ST_CMP_HDR = 4'b0110,
    ST_PORT    = 4'b0111,
    ST_CMP_PAR = 4'b1000,
    ST_WEIGHTS = 4'b1001,
    ST_PAD     = 4'b1010,
    ST_SKIP    = 4'b1011
  } parse_state_t;
endpackage : beam_ext_pkg

// ---- rtl/beam_port_table.sv ----
// Per-port beam and bitmap store for the extension parser.
// Assumes the parser writes one whole record per port and reads only committed entries.
module beam_port_table
  import beam_ext_pkg::*;
#(
  parameter int PORTS = MAX_PORTS
)
(
  input  wire logic                      ref_clk,  // Byte clock
  input  wire logic [PORT_COUNT_W-1:0]   wr_port,  // Port written
  input  wire logic                      wr_en,    // Write strobe
  input  wire logic [ELEMENT_BITS-1:0]   wr_elem,  // Element bitmap in
  input  wire logic [SYMBOL_BITS-1:0]    wr_sym,   // Symbol bitmap in
  input  wire logic [BEAM_BITS-1:0]      wr_beam,  // Beam index in
  input  wire logic [PORT_COUNT_W-1:0]   rd_port,  // Port read
  output logic      [ELEMENT_BITS-1:0]   rd_elem,  // Element bitmap out
  output logic      [SYMBOL_BITS-1:0]    rd_sym,   // Symbol bitmap out
  output logic      [BEAM_BITS-1:0]      rd_beam   // Beam index out
);
  logic [ELEMENT_BITS+SYMBOL_BITS+BEAM_BITS-1:0] store [PORTS];

  // Kept across extensions so a repeated section reuses earlier beam indices and bitmaps
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      store[wr_port] <= {wr_elem, wr_sym, wr_beam};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    {rd_elem, rd_sym, rd_beam} <= store[rd_port];
  end
endmodule : beam_port_table

// ---- rtl/compact_multiport_beam_ext_parser.sv ----
// Receive-side parser for the compact multi-port beamforming section extension.
// Assumes bytes arrive one per clock with in_valid, extension octet N first,
// and that the section type and header element bitmap are stable until the extension closes.
module compact_multiport_beam_ext_parser
  import beam_ext_pkg::*;
#(
  parameter int CMP_HDR_OCTETS  = 1,  // Compression header length
  parameter int CMP_PAR_OCTETS  = 1,  // Compression parameter length
  parameter int WEIGHT_OCTETS   = 2,  // One weight value length
  parameter int TRX_COUNT       = 4,  // Configured transceivers
  parameter int SLOT_SYMBOLS    = 14  // Symbols in a slot
)
(
  input  wire logic                    ref_clk,        // Clock
  input  wire logic                    srst,           // Sync reset, high
  input  wire logic                    in_valid,       // Byte valid
  input  wire logic [7:0]              in_byte,        // Extension byte
  input  wire logic                    in_start,       // First byte of an extension
  input  wire logic [3:0]              section_kind,   // Section type of carrier
  input  wire logic [ELEMENT_BITS-1:0] section_element_bitmap, // Header element bitmap
  input  wire logic [PORT_COUNT_W-1:0] lookup_port,    // Port to read back
  output logic                         more_extensions_flag,   // Another extension follows
  output logic                         weights_off_flag,       // Weights absent
  output logic                         repeat_flag,            // Reuse stored info
  output logic [PORT_COUNT_W:0]        antenna_port_count,     // Ports described
  output logic [SYMBOL_BITS-1:0]       consolidated_symbol_bitmap, // Slot-limited bitmap
  output logic [7:0]                   weight_out,     // Weight byte, I before Q
  output logic                         weight_valid,   // Weight byte strobe
  output logic                         ext_done,       // Extension accepted, pulse
  output logic                         format_error,   // Extension discarded, pulse
  output logic                         element_mismatch, // Header bitmap disagrees, pulse
  output logic [ELEMENT_BITS-1:0]      per_port_element_bitmap, // Stored, lowest freq on top
  output logic [SYMBOL_BITS-1:0]       per_port_symbol_bitmap,  // Stored
  output logic [BEAM_BITS-1:0]         per_port_beam_index      // Stored, replaces header beam
);
  // ****************************************************************
  // Parsing state
  // ****************************************************************
  localparam logic [SYMBOL_BITS-1:0] SLOT_MASK = SYMBOL_BITS'((1 << SLOT_SYMBOLS) - 1);
  localparam int PORT_OCTETS = 6;

  parse_state_t              state;
  logic [15:0]               length_field;
  logic [15:0]               consumed;
  logic [15:0]               field_cnt;
  logic [PORT_COUNT_W:0]     port_idx;
  logic [PORT_COUNT_W:0]     ports;
  logic                      off_bit;
  logic                      rep_bit;
  logic [ELEMENT_BITS-1:0]   elem_acc;
  logic [ELEMENT_BITS-1:0]   elem_or;
  logic [SYMBOL_BITS-1:0]    sym_acc;
  logic [BEAM_BITS-1:0]      beam_acc;
  logic [SYMBOL_BITS-1:0]    sym_hold;
  logic                      ef_hold;
  logic                      wr_en;
  logic [PORT_COUNT_W-1:0]   wr_port;

  function automatic logic pad_ok(input logic [15:0] n);
    pad_ok = (n[1:0] == 2'b00);
  endfunction : pad_ok

  wire logic section_ok = (section_kind == SECTION_KIND_ONE) || (section_kind == SECTION_KIND_THREE);
  wire logic kind_ok    = (in_byte[6:0] == EXT_KIND_CODE);
  wire logic [15:0] next_consumed = consumed + 16'h0001;
  // Length counts four-octet words; contents end exactly at length
  wire logic [15:0] ext_octets = 16'(length_field * LEN_UNIT_OCTETS);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state      <= ST_IDLE;
      consumed   <= 16'h0000;
      field_cnt  <= 16'h0000;
      port_idx   <= '0;
      ports      <= '0;
      off_bit    <= 1'b0;
      rep_bit    <= 1'b0;
      length_field <= 16'h0000;
      elem_acc   <= '0;
      elem_or    <= '0;
      sym_acc    <= '0;
      beam_acc   <= '0;
      sym_hold   <= '0;
      ef_hold    <= 1'b0;
      wr_en      <= 1'b0;
      wr_port    <= '0;
      weight_valid <= 1'b0;
      weight_out <= 8'h00;
      ext_done   <= 1'b0;
      format_error <= 1'b0;
      element_mismatch <= 1'b0;
      more_extensions_flag <= 1'b0;
      weights_off_flag <= 1'b0;
      repeat_flag <= 1'b0;
      antenna_port_count <= '0;
      consolidated_symbol_bitmap <= '0;
    end
    else
    begin
      wr_en        <= 1'b0;
      weight_valid <= 1'b0;
      ext_done     <= 1'b0;
      format_error <= 1'b0;
      element_mismatch <= 1'b0;
      if (in_valid)
      begin
        consumed <= next_consumed;
        unique case (state)
          ST_IDLE:
          begin
            // Coupling method plays no part in acceptance
            if (in_start && section_ok && kind_ok)
            begin
              consumed <= 16'h0001;
              // Held back until a clean close so a discarded extension leaves the flag alone
              ef_hold <= in_byte[MORE_FLAG_BIT];
              elem_or <= '0;
              state   <= ST_LEN_HI;
            end
            else
            begin
              consumed <= 16'h0000;
            end
          end
          ST_LEN_HI:
          begin
            length_field[15:8] <= in_byte;
            state <= ST_LEN_LO;
          end
          ST_LEN_LO:
          begin
            length_field[7:0] <= in_byte;
            state <= ST_FLAGS;
          end
          ST_FLAGS:
          begin
            off_bit <= in_byte[WEIGHTS_OFF_BIT];
            rep_bit <= in_byte[REPEAT_BIT];
            // Zero count taken as 64 so all 64 ports fit in six bits
            ports   <= (in_byte[5:0] == 6'h00) ? 7'(MAX_PORTS) : {1'b0, in_byte[5:0]};
            state   <= ST_SYM_HI;
          end
          ST_SYM_HI:
          begin
            sym_hold[13:8] <= in_byte[5:0];
            state <= ST_SYM_LO;
          end
          ST_SYM_LO:
          begin
            sym_hold[7:0] <= in_byte;
            field_cnt <= 16'h0000;
            port_idx  <= '0;
            if (off_bit || rep_bit)
            begin
              state <= rep_bit ? ST_PAD : ST_PORT;
            end
            else
            begin
              state <= ST_CMP_HDR;
            end
          end
          ST_CMP_HDR:
          begin
            field_cnt <= field_cnt + 16'h0001;
            if (field_cnt == 16'(CMP_HDR_OCTETS - 1))
            begin
              field_cnt <= 16'h0000;
              state <= ST_PORT;
            end
          end
          ST_PORT:
          begin
            field_cnt <= field_cnt + 16'h0001;
            unique case (field_cnt[2:0])
              3'd0: elem_acc[11:8]  <= in_byte[3:0];
              3'd1: elem_acc[7:0]   <= in_byte;
              3'd2: sym_acc[13:8]   <= in_byte[5:0];
              3'd3: sym_acc[7:0]    <= in_byte;
              3'd4: beam_acc[14:8]  <= in_byte[6:0];
              default: beam_acc[7:0] <= in_byte;
            endcase
            if (field_cnt == 16'(PORT_OCTETS - 1))
            begin
              field_cnt <= 16'h0000;
              state <= off_bit ? ST_PAD : ST_CMP_PAR;
              wr_en   <= 1'b1;
              wr_port <= port_idx[PORT_COUNT_W-1:0];
              elem_or <= elem_or | elem_acc;
              port_idx <= port_idx + 7'h01;
              if (off_bit && (port_idx + 7'h01 < ports))
              begin
                state <= ST_PORT;
              end
            end
          end
          ST_CMP_PAR:
          begin
            field_cnt <= field_cnt + 16'h0001;
            if (field_cnt == 16'(CMP_PAR_OCTETS - 1))
            begin
              field_cnt <= 16'h0000;
              state <= ST_WEIGHTS;
            end
          end
          ST_WEIGHTS:
          begin
            // Bytes pass in transceiver order, in-phase value first
            weight_out   <= in_byte;
            weight_valid <= 1'b1;
            field_cnt <= field_cnt + 16'h0001;
            if (field_cnt == 16'(2 * WEIGHT_OCTETS * TRX_COUNT - 1))
            begin
              field_cnt <= 16'h0000;
              state <= (port_idx < ports) ? ST_PORT : ST_PAD;
            end
          end
          ST_PAD, ST_SKIP:
          begin
            state <= ST_SKIP;
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
      // Close-out checks once the declared length has been consumed or a non-zero byte arrives in pad
      if ((state == ST_PAD || state == ST_SKIP) && (consumed == ext_octets || (in_valid && in_byte != PAD_OCTET)))
      begin
        state <= ST_IDLE;
        if (consumed == ext_octets && pad_ok(consumed))
        begin
          ext_done <= 1'b1;
          more_extensions_flag <= ef_hold;
          weights_off_flag <= off_bit;
          repeat_flag <= rep_bit;
          antenna_port_count <= ports;
          consolidated_symbol_bitmap <= sym_hold & SLOT_MASK;
          element_mismatch <= !rep_bit && (elem_or != section_element_bitmap);
        end
        else
        begin
          format_error <= 1'b1;
        end
      end
      else if (state != ST_IDLE && state != ST_PAD && state != ST_SKIP && in_valid && next_consumed > ext_octets
               && state > ST_LEN_LO)
      begin
        state <= ST_IDLE;
        format_error <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Per-port store; header beam index is never consulted
  // ****************************************************************
  beam_port_table #(.PORTS(MAX_PORTS)) u_table
  (
    .ref_clk (ref_clk),
    .wr_port (wr_port),
    .wr_en   (wr_en),
    .wr_elem (elem_acc),
    .wr_sym  (sym_acc),
    .wr_beam (beam_acc),
    .rd_port (lookup_port),
    .rd_elem (per_port_element_bitmap),
    .rd_sym  (per_port_symbol_bitmap),
    .rd_beam (per_port_beam_index)
  );
endmodule : compact_multiport_beam_ext_parser

// ---- verif/beam_ext_sva.sv ----
// Port-level checker for the beam extension parser.
// Assumes one clock and the synchronous reset of the parser.
module beam_ext_sva
  import beam_ext_pkg::*;
#(
  parameter int SLOT_SYMBOLS = 14
)
(
  input wire logic                    ref_clk,   // Clock
  input wire logic                    srst,      // Reset
  input wire logic                    in_valid,  // Byte valid
  input wire logic                    in_start,  // First byte
  input wire logic [3:0]              section_kind, // Section type
  input wire logic                    weight_valid, // Weight strobe
  input wire logic                    ext_done,     // Accept pulse
  input wire logic                    format_error, // Discard pulse
  input wire logic                    element_mismatch, // Bitmap pulse
  input wire logic [PORT_COUNT_W:0]   antenna_port_count, // Ports
  input wire logic [SYMBOL_BITS-1:0]  consolidated_symbol_bitmap, // Symbols
  input wire logic                    more_extensions_flag, // Next extension flag
  input wire logic                    weights_off_flag, // Weights absent
  input wire logic                    repeat_flag  // Reuse stored info
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_done_err_excl: assert property (!(ext_done && format_error))
    else $error("done and error together");
  chk_err_no_mism: assert property (format_error |-> !element_mismatch)
    else $error("mismatch on discarded extension");
  chk_mism_with_done: assert property (element_mismatch |-> ext_done)
    else $error("mismatch without done");
  chk_done_kind: assert property (ext_done |-> section_kind inside {4'h1, 4'h3})
    else $error("done in wrong section type");
  // Shortest extension is eight octets, so two accepts cannot be closer
  chk_done_spacing: assert property (ext_done |=> !ext_done [*7])
    else $error("accepts too close");
  chk_weight_cause: assert property (weight_valid |-> $past(in_valid))
    else $error("weight without byte");
  chk_no_weight_kind: assert property (weight_valid |-> !$past(in_start))
    else $error("kind byte sent as weight");
  chk_slot_limit: assert property ((consolidated_symbol_bitmap >> SLOT_SYMBOLS) == 0)
    else $error("symbol past slot end");
  chk_count_range: assert property (ext_done |=> antenna_port_count inside {[1:64]})
    else $error("port count out of range");
  // Results move only on a clean accept; a discarded extension must not touch them
  chk_flags_on_done: assert property ($changed({more_extensions_flag, weights_off_flag, repeat_flag,
                                               antenna_port_count, consolidated_symbol_bitmap}) |-> ext_done)
    else $error("result flags changed without accept");
  cover property (ext_done);
  cover property (format_error);
  cover property (element_mismatch);
  cover property (weight_valid ##1 weight_valid);
endmodule : beam_ext_sva

bind compact_multiport_beam_ext_parser beam_ext_sva #(.SLOT_SYMBOLS(SLOT_SYMBOLS)) u_sva
(
  .ref_clk(ref_clk), .srst(srst), .in_valid(in_valid), .in_start(in_start),
  .section_kind(section_kind), .weight_valid(weight_valid), .ext_done(ext_done),
  .format_error(format_error), .element_mismatch(element_mismatch),
  .antenna_port_count(antenna_port_count), .consolidated_symbol_bitmap(consolidated_symbol_bitmap),
  .more_extensions_flag(more_extensions_flag), .weights_off_flag(weights_off_flag), .repeat_flag(repeat_flag)
);

// ---- verif/du_byte_source.sv ----
// Byte source standing in for the sending unit.
// Assumes the bench fills octet[] and calls send just after a rising edge.
module du_byte_source
(
  input  wire logic       ref_clk,  // Byte clock
  output logic            in_valid, // Byte valid
  output logic [7:0]      in_byte,  // Extension byte
  output logic            in_start  // First byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] octet [0:511];
  bit         stall;
  initial
  begin
    in_valid = 1'b0;
    in_byte  = 8'hA5;
    in_start = 1'b0;
    stall    = 1'b0;
  end
  // Frame image already holds headers, records and zero padding
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      while (stall && $urandom_range(3) == 0)
      begin
        in_valid = 1'b0;
        in_byte  = ~in_byte;
        @(posedge ref_clk) #1;
      end
      in_valid = 1'b1;
      in_byte  = octet[i];
      in_start = (i == 0);
      @(posedge ref_clk) #1;
    end
    in_valid = 1'b0;
    in_start = 1'b0;
    in_byte  = ~in_byte;
  endtask : send
endmodule : du_byte_source

// ---- verif/tb_top.sv ----
// Self-checking bench for the beam extension parser.
// Assumes the byte source model and a 100 MHz byte clock.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import beam_ext_pkg::*;
  localparam int TRANSCEIVER_INDEX  = 2;
  localparam int SLOT = 12;
  logic ref_clk, srst, in_valid, in_start, wv, done, ferr, mism, ef, wo, rp;
  logic [7:0] in_byte, wout;
  logic [3:0] section_kind;
  logic [11:0] hbm, pe;
  logic [13:0] ps, csb;
  logic [14:0] pb;
  logic [5:0] lp;
  logic [6:0] apc;
  int err_count, checked, n_done, n_err, n_mism, flen, tn;
  logic [11:0] x_e [64];
  logic [13:0] x_s [64];
  logic [14:0] x_b [64];
  logic [7:0] wq [$];
  logic [11:0] hor;
  logic [31:0] b_f, e_f;
  du_byte_source src (.ref_clk(ref_clk), .in_valid(in_valid), .in_byte(in_byte), .in_start(in_start));
  compact_multiport_beam_ext_parser #(.TRX_COUNT(TRANSCEIVER_INDEX), .SLOT_SYMBOLS(SLOT)) dut
  (
    .ref_clk(ref_clk), .srst(srst), .in_valid(in_valid), .in_byte(in_byte), .in_start(in_start),
    .section_kind(section_kind), .section_element_bitmap(hbm), .lookup_port(lp),
    .more_extensions_flag(ef), .weights_off_flag(wo), .repeat_flag(rp), .antenna_port_count(apc),
    .consolidated_symbol_bitmap(csb), .weight_out(wout), .weight_valid(wv), .ext_done(done),
    .format_error(ferr), .element_mismatch(mism), .per_port_element_bitmap(pe),
    .per_port_symbol_bitmap(ps), .per_port_beam_index(pb)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk)
  begin
    n_done += (done === 1'b1);
    n_err  += (ferr === 1'b1);
    n_mism += (done === 1'b1 && mism === 1'b1);
    if (wv === 1'b1)
      check(wout, wq.size() ? wq.pop_front() : 8'hXX);
  end
  task automatic put(inout int n, input logic [7:0] v);
    src.octet[n] = v;
    n++;
  endtask : put
  // Builds one frame image and the values the parser must report for it
  task automatic build(input int np, input bit woff, input bit rep, input int bad);
    int n;
    logic [13:0] s;
    n = 6;
    hor = 12'h000;
    s = 14'($urandom);
    src.octet[0] = {1'($urandom), EXT_KIND_CODE};
    src.octet[3] = {woff, rep, 6'(np)};
    src.octet[4] = {2'($urandom), s[13:8]};
    src.octet[5] = s[7:0];
    b_f = {src.octet[0][7], woff, rep, 7'(np == 0 ? 64 : np), s & 14'((1 << SLOT) - 1)};
    if (!(woff || rep))
      put(n, 8'($urandom));
    for (int p = 0; p < (rep ? 0 : (np == 0 ? 64 : np)); p++)
    begin
      x_e[p] = 12'($urandom);
      x_s[p] = 14'($urandom);
      x_b[p] = 15'($urandom);
      hor |= x_e[p];
      put(n, {4'h0, x_e[p][11:8]});
      put(n, x_e[p][7:0]);
      put(n, {2'b00, x_s[p][13:8]});
      put(n, x_s[p][7:0]);
      put(n, {1'b0, x_b[p][14:8]});
      put(n, x_b[p][7:0]);
      if (!woff)
      begin
        put(n, 8'($urandom));
        for (int k = 0; k < TRANSCEIVER_INDEX * 4; k++)
        begin
          put(n, 8'($urandom));
          wq.push_back(src.octet[n - 1]);
        end
      end
    end
    while (n % 4 != 0 || bad == 1 && n % 8 != 4)
      put(n, PAD_OCTET);
    if (bad == 1)
      src.octet[n - 1] = 8'h5A;
    {src.octet[1], src.octet[2]} = 16'(n / 4 - (bad == 2));
    flen = n;
  endtask : build
  task automatic run(input logic [3:0] kind, input int xd, input int xe, input bit xm);
    int d, e, m;
    d = n_done;
    e = n_err;
    m = n_mism;
    section_kind = kind;
    hbm = hor ^ {11'h0, xm};
    src.send(flen);
    repeat (20) @(posedge ref_clk) #1;
    check(n_done - d, xd);
    check(n_err - e, xe);
    check(n_mism - m, xm);
    if (xd)
      e_f = b_f;
    check({ef, wo, rp, apc, csb}, e_f);
    tn++;
    $display("Test %0d finished", tn);
  endtask : run
  // Reads back first, last and one random port of the stored table
  task automatic peek(input int np);
    int pl [3];
    pl = '{0, np - 1, $urandom_range(np - 1)};
    foreach (pl[i])
    begin
      lp = 6'(pl[i]);
      repeat (2) @(posedge ref_clk) #1;
      check({pe, ps, pb}, {x_e[pl[i]], x_s[pl[i]], x_b[pl[i]]});
    end
  endtask : peek
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    give_verdict;
  end
  initial
  begin
    void'($urandom(32'hD4E06CEE));
    {srst, section_kind, hbm, lp, e_f} = {1'b1, 4'h1, 12'h000, 6'h00, 32'h0};
    repeat (5) @(posedge ref_clk);
    #1 srst = 1'b0;
    build(3, 0, 0, 0);
    run(SECTION_KIND_ONE, 1, 0, 0);
    peek(3);
    src.stall = 1'b1;
    build(5, 1, 0, 0);
    run(SECTION_KIND_THREE, 1, 0, 1);
    peek(5);
    build(2, 0, 1, 0);
    run(SECTION_KIND_ONE, 1, 0, 0);
    peek(5);
    build(0, 1, 0, 0);
    run(SECTION_KIND_THREE, 1, 0, 0);
    peek(64);
    build(2, 1, 0, 0);
    run(4'h2, 0, 0, 0);
    build(2, 1, 0, 1);
    run(SECTION_KIND_THREE, 0, 1, 0);
    build(2, 1, 0, 2);
    run(SECTION_KIND_ONE, 0, 1, 0);
    build(1, 1, 0, 0);
    src.octet[0][6:0] = 7'h12;
    run(SECTION_KIND_ONE, 0, 0, 0);
    check(wq.size(), 0);
    give_verdict;
  end
endmodule : tb_top
